// File: inc/lpmsc_pkg.sv
// Package for the panel mode and size control block: register map, fields, reset values.
// Assumes a 32-bit APB register bus with one register per aligned word.
`default_nettype none
package lpmsc_pkg;
  // ==========================================================================
  // Register offsets (printed offsets are not word multiples, so index * 4).
  localparam logic [17:0] LPMSC_IDX_MODE1    = 18'h1ffe2;
  localparam logic [17:0] LPMSC_IDX_MODE2    = 18'h1ffe3;
  localparam logic [17:0] LPMSC_IDX_HSIZE    = 18'h1ffe4;
  localparam logic [17:0] LPMSC_IDX_VSIZE_LO = 18'h1ffe5;
  localparam logic [17:0] LPMSC_IDX_VSIZE_HI = 18'h1ffe6;
  localparam logic [17:0] LPMSC_IDX_LPSTART  = 18'h1ffe7;
  localparam logic [17:0] LPMSC_IDX_GPCFG    = 18'h1fff8;
  localparam logic [17:0] LPMSC_IDX_GPCTL    = 18'h1fff9;
  localparam logic [17:0] LPMSC_IDX_STATUS   = 18'h1fffa;
  localparam int          LPMSC_AW           = 20;
  // ==========================================================================
  // Field positions.
  localparam int LPMSC_M1_SWINV_BIT = 0;
  localparam int LPMSC_M1_HWINV_BIT = 1;
  localparam int LPMSC_M1_TFT_BIT   = 7;
  localparam int LPMSC_M2_OVR_BIT   = 3;
  localparam int LPMSC_M2_HWPS_BIT  = 2;
  localparam int LPMSC_GP0_BIT      = 0;
  localparam int LPMSC_GP4_BIT      = 4;
  // ==========================================================================
  // Writable masks; unused bits are held at zero.
  localparam logic [7:0] LPMSC_M1_MASK    = 8'h83;
  localparam logic [7:0] LPMSC_M2_MASK    = 8'h0f;
  localparam logic [7:0] LPMSC_HSIZE_MASK = 8'h7f;
  localparam logic [7:0] LPMSC_VHI_MASK   = 8'h03;
  localparam logic [7:0] LPMSC_LPS_MASK   = 8'h1f;
  localparam logic [7:0] LPMSC_GP_MASK    = 8'h11;
  // ==========================================================================
  // Reset values and encodings.
  localparam logic [7:0] LPMSC_RST_MODE1  = 8'h00;
  localparam logic [7:0] LPMSC_RST_MODE2  = 8'h00;
  localparam logic [7:0] LPMSC_RST_HSIZE  = 8'h03;
  localparam logic [7:0] LPMSC_RST_VSIZE  = 8'h00;
  localparam logic [7:0] LPMSC_RST_LPS    = 8'h00;
  localparam logic [1:0] LPMSC_PS_SLEEP   = 2'h0;
  localparam logic [1:0] LPMSC_PS_NORMAL  = 2'h3;
  localparam int         LPMSC_LP_BIAS    = 2;
  localparam int         LPMSC_LP_UNIT    = 8;
endpackage : lpmsc_pkg
`default_nettype wire

// File: src/lpmsc_video_out.sv
// Pixel output stage: inversion after the look-up table and power-save forcing.
// Assumes pixel data arrive already translated by the colour look-up table.
`default_nettype none
module lpmsc_video_out #(
  parameter int DW = 12
) (
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Pixel in and controls.
  input  wire logic [DW-1:0] lut_data_i,
  input  wire logic          invert_i,
  input  wire logic          force_low_i,
  // Pixel out.
  output logic      [DW-1:0] pix_o
);
  typedef struct packed {
    logic [DW-1:0] pix;
  } lpmsc_vo_st_t;
  lpmsc_vo_st_t s_q;
  lpmsc_vo_st_t s_d;

  // ==========================================================================
  // Inversion is applied to the table output so colour indices stay intact.
  always_comb begin
    s_d = s_q;
    s_d.pix = invert_i ? ~lut_data_i : lut_data_i;
    if (force_low_i) begin
      s_d.pix = '0;
    end
  end

  // Registered so the panel sees clean data edges.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pix_o = s_q.pix;
endmodule : lpmsc_video_out
`default_nettype wire

// File: src/lpmsc_top.sv
// Panel mode and size control: mode registers, panel sizes, line-pulse position,
// video invert selection, power override and the general pin zero / four logic.
// Assumes an APB master on MCLK_I and a sequencer that supplies power-up timing.
// Function
// - Invert video after the look-up table.
// - Software invert bit selects inverse video.
// - Hardware invert uses pin bit 11 level on passive panels only.
// - Pin bit 11 is pin four or invert.
// - Override clear: power follows sequencing logic.
// - Override set: power off, signals low immediately in power save.
// - Hardware power save uses pin zero input.
// - Pin zero input or driven control value.
// - Power save field: 00 sleep, 11 normal.
// - Vertical size split over low/high registers.
// - Largest vertical value 3ff, 1024 lines.
// - Line-pulse start field five bits wide.
// - TFT line pulse at (field+2)*8 pixels.
`default_nettype none
module lpmsc_top
  import lpmsc_pkg::*;
#(
  parameter int DW = 12
) (
  // Clock and reset.
  input  wire logic                MCLK_I,
  input  wire logic                RSTN_I,
  // APB slave.
  input  wire logic                PSEL_I,
  input  wire logic                PENABLE_I,
  input  wire logic                PWRITE_I,
  input  wire logic [LPMSC_AW-1:0] PADDR_I,
  input  wire logic [31:0]         PWDATA_I,
  output logic      [31:0]         PRDATA_O,
  output logic                     PREADY_O,
  output logic                     PSLVERR_O,
  // Pixel path.
  input  wire logic [DW-1:0]       LUT_DATA_I,
  input  wire logic                LINE_END_I,
  input  wire logic                SEQ_POWER_I,
  output logic      [DW-1:0]       PANEL_DATA_BUS_O,
  output logic                     PANEL_POWER_OUT_O,
  output logic                     LINE_PULSE_O,
  // Panel data bit 11 pin in its pin-four and hardware invert roles.
  input  wire logic                PANEL_DATA_BIT11_PIN_I,
  output logic                     PANEL_DATA_BIT11_PIN_O,
  output logic                     PANEL_DATA_BIT11_PIN_OE_O,
  // General pin zero.
  input  wire logic                GENERAL_PIN_ZERO_I,
  output logic                     GENERAL_PIN_ZERO_O,
  output logic                     GENERAL_PIN_ZERO_OE_O,
  // Status.
  output logic                     POWER_SAVE_O
);
  // ==========================================================================
  // State.
  typedef enum logic [1:0] {
    LPMSC_LP_IDLE  = 2'b01,
    LPMSC_LP_COUNT = 2'b10
  } lpmsc_lp_t;

  typedef struct packed {
    logic [7:0]  mode1;
    logic [7:0]  mode2;
    logic [7:0]  hsize;
    logic [7:0]  vlo;
    logic [7:0]  vhi;
    logic [7:0]  lps;
    logic [7:0]  gpcfg;
    logic [7:0]  gpctl;
    logic [31:0] rdata;
    lpmsc_lp_t   lp_st;
    logic [8:0]  lp_cnt;
    logic        lp_pulse;
    logic        pwr;
  } lpmsc_st_t;

  lpmsc_st_t s_q;
  lpmsc_st_t s_d;

  logic [17:0] idx;
  logic        mapped;
  logic        wr_en;
  logic        rd_en;
  logic        tft;
  logic        hw_inv_en;
  logic        hw_ps_en;
  logic        ps_active;
  logic        invert;
  logic        force_low;
  logic [9:0]  vsize;
  logic [7:0]  status;
  logic [7:0]  rd_byte;
  logic [8:0]  lp_target;

  // ==========================================================================
  // Address decode: each register is one aligned word at four times its index.
  assign idx    = PADDR_I[19:2];
  assign wr_en  = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en  = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign mapped = (idx == LPMSC_IDX_MODE1) || (idx == LPMSC_IDX_MODE2)
               || (idx == LPMSC_IDX_HSIZE) || (idx == LPMSC_IDX_VSIZE_LO)
               || (idx == LPMSC_IDX_VSIZE_HI) || (idx == LPMSC_IDX_LPSTART)
               || (idx == LPMSC_IDX_GPCFG) || (idx == LPMSC_IDX_GPCTL)
               || (idx == LPMSC_IDX_STATUS);

  // ==========================================================================
  // Mode decode.
  assign tft       = s_q.mode1[LPMSC_M1_TFT_BIT];
  assign hw_inv_en = s_q.mode1[LPMSC_M1_HWINV_BIT];
  assign hw_ps_en  = s_q.mode2[LPMSC_M2_HWPS_BIT];
  assign vsize     = {s_q.vhi[1:0], s_q.vlo};

  // pin zero as hardware request
  // Reserved field codes are treated as normal operation: the safe display-on choice.
  assign ps_active = (s_q.mode2[1:0] == LPMSC_PS_SLEEP)
                  || (hw_ps_en && GENERAL_PIN_ZERO_I);

  // hardware invert from pin
  // The pin only means invert on passive panels; TFT panels use bit 11 as data.
  assign invert = (hw_inv_en && !tft) ? PANEL_DATA_BIT11_PIN_I
                                       : s_q.mode1[LPMSC_M1_SWINV_BIT];

  // otherwise sequencer owns it
  // Without override the sequencer drops power itself once power save is seen.
  assign force_low = ps_active && s_q.mode2[LPMSC_M2_OVR_BIT];

  // pulse offset in clock units
  // Nine bits: the largest offset, (31 + 2) * 8, does not fit in a byte.
  assign lp_target = 9'((32'(s_q.lps[4:0]) + LPMSC_LP_BIAS) * LPMSC_LP_UNIT - 1);

  // Status: power save state in bit one; the other bits read zero.
  assign status = {6'h00, ps_active, 1'b0};

  // ==========================================================================
  // Read data mux; unused bits are masked in storage so they read zero.
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      LPMSC_IDX_MODE1:    rd_byte = s_q.mode1;
      LPMSC_IDX_MODE2:    rd_byte = s_q.mode2;
      LPMSC_IDX_HSIZE:    rd_byte = s_q.hsize;
      LPMSC_IDX_VSIZE_LO: rd_byte = s_q.vlo;
      LPMSC_IDX_VSIZE_HI: rd_byte = s_q.vhi;
      LPMSC_IDX_LPSTART:  rd_byte = s_q.lps;
      LPMSC_IDX_GPCFG:    rd_byte = s_q.gpcfg;
      LPMSC_IDX_GPCTL: begin
        rd_byte = s_q.gpctl;
        if (!s_q.gpcfg[LPMSC_GP0_BIT]) begin
          rd_byte[LPMSC_GP0_BIT] = GENERAL_PIN_ZERO_I;
        end
        if (!s_q.gpcfg[LPMSC_GP4_BIT]) begin
          rd_byte[LPMSC_GP4_BIT] = PANEL_DATA_BIT11_PIN_I;
        end
      end
      LPMSC_IDX_STATUS:   rd_byte = status;
      default:            rd_byte = 8'h00;
    endcase
  end

  // ==========================================================================
  // Next-state logic: register writes, line-pulse timer, power output.
  always_comb begin
    s_d = s_q;
    if (rd_en) begin
      s_d.rdata = {24'h000000, rd_byte};
    end
    if (wr_en) begin
      unique case (idx)
        LPMSC_IDX_MODE1:    s_d.mode1 = PWDATA_I[7:0] & LPMSC_M1_MASK;
        LPMSC_IDX_MODE2:    s_d.mode2 = PWDATA_I[7:0] & LPMSC_M2_MASK;
        LPMSC_IDX_HSIZE:    s_d.hsize = PWDATA_I[7:0] & LPMSC_HSIZE_MASK;
        LPMSC_IDX_VSIZE_LO: s_d.vlo   = PWDATA_I[7:0];
        LPMSC_IDX_VSIZE_HI: s_d.vhi   = PWDATA_I[7:0] & LPMSC_VHI_MASK;
        LPMSC_IDX_LPSTART:  s_d.lps   = PWDATA_I[7:0] & LPMSC_LPS_MASK;
        LPMSC_IDX_GPCFG:    s_d.gpcfg = PWDATA_I[7:0] & LPMSC_GP_MASK;
        LPMSC_IDX_GPCTL:    s_d.gpctl = PWDATA_I[7:0] & LPMSC_GP_MASK;
        default:            s_d.mode1 = s_q.mode1;
      endcase
    end

    s_d.lp_pulse = 1'b0;
    unique case (s_q.lp_st)
      LPMSC_LP_IDLE: begin
        if (LINE_END_I && tft && !force_low) begin
          s_d.lp_st  = LPMSC_LP_COUNT;
          s_d.lp_cnt = 9'h000;
        end
      end
      LPMSC_LP_COUNT: begin
        if (!tft || force_low) begin
          s_d.lp_st = LPMSC_LP_IDLE;
        end else if (s_q.lp_cnt == lp_target) begin
          s_d.lp_pulse = 1'b1;
          s_d.lp_st    = LPMSC_LP_IDLE;
        end else begin
          s_d.lp_cnt = s_q.lp_cnt + 9'h001;
        end
      end
      default: begin
        s_d.lp_st = LPMSC_LP_IDLE;
      end
    endcase

    s_d.pwr = SEQ_POWER_I && !force_low;
  end

  // Single state register.
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      s_q          <= '0;
      s_q.mode1    <= LPMSC_RST_MODE1;
      s_q.mode2    <= LPMSC_RST_MODE2;
      s_q.hsize    <= LPMSC_RST_HSIZE;
      s_q.vlo      <= LPMSC_RST_VSIZE;
      s_q.vhi      <= LPMSC_RST_VSIZE;
      s_q.lps      <= LPMSC_RST_LPS;
      s_q.lp_st    <= LPMSC_LP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Pixel output stage.
  lpmsc_video_out #(
    .DW          (DW)
  ) u_video (
    .clk_i       (MCLK_I),
    .rst_n_i     (RSTN_I),
    .lut_data_i  (LUT_DATA_I),
    .invert_i    (invert),
    .force_low_i (force_low),
    .pix_o       (PANEL_DATA_BUS_O)
  );

  // ==========================================================================
  // Pins. During reset every driver is off, so both pins float as inputs.
  // config ignored under hardware save
  assign GENERAL_PIN_ZERO_OE_O     = RSTN_I && !hw_ps_en && s_q.gpcfg[LPMSC_GP0_BIT];
  assign GENERAL_PIN_ZERO_O        = s_q.gpctl[LPMSC_GP0_BIT];
  // pin four only on passive without invert
  assign PANEL_DATA_BIT11_PIN_OE_O = RSTN_I && !tft && !hw_inv_en
                                  && s_q.gpcfg[LPMSC_GP4_BIT] && !force_low;
  assign PANEL_DATA_BIT11_PIN_O    = s_q.gpctl[LPMSC_GP4_BIT];

  assign PANEL_POWER_OUT_O = s_q.pwr;
  assign LINE_PULSE_O      = s_q.lp_pulse;
  assign POWER_SAVE_O      = ps_active;
  assign PRDATA_O          = s_q.rdata;
  // Zero-wait access; a miss is flagged but never stalls the bus.
  assign PREADY_O          = 1'b1;
  assign PSLVERR_O         = PSEL_I && PENABLE_I && !mapped;

  // vsize and hsize are kept for the timing generator outside this block.
  logic unused_ok;
  assign unused_ok = ^{vsize, s_q.hsize};
endmodule : lpmsc_top
`default_nettype wire

// File: bench/lpmsc_checker.sv
// Concurrent checks on the ports of the panel mode and size control block.
// Assumes only top-level ports; mode and pin registers are shadowed from APB writes.
`default_nettype none
module lpmsc_checker
  import lpmsc_pkg::*;
#(
  parameter int DW = 12
) (
  // Clock, reset and APB.
  input wire logic                MCLK_I, RSTN_I, PSEL_I, PENABLE_I, PWRITE_I,
  input wire logic                PREADY_O, PSLVERR_O,
  input wire logic [LPMSC_AW-1:0] PADDR_I,
  input wire logic [31:0]         PWDATA_I, PRDATA_O,
  // Pixel path, pins and status.
  input wire logic [DW-1:0]       LUT_DATA_I, PANEL_DATA_BUS_O,
  input wire logic                LINE_END_I, SEQ_POWER_I, PANEL_POWER_OUT_O, LINE_PULSE_O,
  input wire logic                PANEL_DATA_BIT11_PIN_I, PANEL_DATA_BIT11_PIN_O,
  input wire logic                PANEL_DATA_BIT11_PIN_OE_O, POWER_SAVE_O,
  input wire logic                GENERAL_PIN_ZERO_I, GENERAL_PIN_ZERO_O, GENERAL_PIN_ZERO_OE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m1_q, m2_q, cfg_q;
  logic       ctl_q, wr, mapped, hw_inv, inv, force_lo;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  // Shadows follow completed writes, so no design internals are needed.
  assign wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      {m1_q, m2_q, cfg_q, ctl_q} <= '0;
    end else if (wr) begin
      if (PADDR_I == {LPMSC_IDX_MODE1, 2'b00}) m1_q <= PWDATA_I[7:0];
      if (PADDR_I == {LPMSC_IDX_MODE2, 2'b00}) m2_q <= PWDATA_I[7:0];
      if (PADDR_I == {LPMSC_IDX_GPCFG, 2'b00}) cfg_q <= PWDATA_I[7:0];
      if (PADDR_I == {LPMSC_IDX_GPCTL, 2'b00}) ctl_q <= PWDATA_I[0];
    end
  end
  // Decoded conditions; hardware invert is ignored in TFT mode.
  assign mapped = PADDR_I[1:0] == 2'h0 && PADDR_I[19:2] inside {LPMSC_IDX_MODE1,
    LPMSC_IDX_MODE2, LPMSC_IDX_HSIZE, LPMSC_IDX_VSIZE_LO, LPMSC_IDX_VSIZE_HI,
    LPMSC_IDX_LPSTART, LPMSC_IDX_GPCFG, LPMSC_IDX_GPCTL, LPMSC_IDX_STATUS};
  assign hw_inv = m1_q[1] && !m1_q[7];
  assign inv = hw_inv ? PANEL_DATA_BIT11_PIN_I : m1_q[0];
  assign force_lo = POWER_SAVE_O && m2_q[3];
  // ==========================================================================
  // Assertions.
  a_ready_high: assert property (PREADY_O) else $error("ready low");
  a_addr_error: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == !mapped)
    else $error("error response wrong");
  a_save_decode: assert property (POWER_SAVE_O ==
    (m2_q[1:0] == 2'h0 || (m2_q[2] && GENERAL_PIN_ZERO_I))) else $error("power save wrong");
  a_force_off: assert property (force_lo |=> !PANEL_POWER_OUT_O
    && PANEL_DATA_BUS_O == '0) else $error("panel not forced low");
  a_power_follow: assert property (!force_lo |=> PANEL_POWER_OUT_O == $past(SEQ_POWER_I))
    else $error("panel power not following sequencer");
  a_invert_sel: assert property (!force_lo |=> PANEL_DATA_BUS_O ==
    ($past(inv) ? ~$past(LUT_DATA_I) : $past(LUT_DATA_I))) else $error("pixel invert wrong");
  a_pin11_input: assert property ((hw_inv)[*2] |-> !PANEL_DATA_BIT11_PIN_OE_O)
    else $error("bit eleven driven in invert role");
  a_pin0_drive: assert property ((!m2_q[2] && cfg_q[0] && $stable(ctl_q))[*2]
    |-> GENERAL_PIN_ZERO_OE_O && GENERAL_PIN_ZERO_O == ctl_q) else $error("pin zero drive");
  a_pin0_input: assert property ((m2_q[2] || !cfg_q[0])[*2] |-> !GENERAL_PIN_ZERO_OE_O)
    else $error("pin zero driven as input");
  a_pulse_single: assert property (LINE_PULSE_O |=> !LINE_PULSE_O)
    else $error("line pulse longer than one cycle");
  a_unused_zero: assert property (PSEL_I && PENABLE_I && !PWRITE_I &&
    PADDR_I == {LPMSC_IDX_LPSTART, 2'b00} |-> PRDATA_O[31:5] == 27'h0) else $error("unused set");
endmodule : lpmsc_checker
`default_nettype wire

// File: bench/lpmsc_panel_model.sv
// Panel-side model of the shared bit-eleven data pin.
// Assumes the bench supplies the level the panel side puts on that pin.
`default_nettype none
module lpmsc_panel_model (
  // Pin bit eleven.
  input  wire logic pin11_o_i,
  input  wire logic pin11_oe_i,
  input  wire logic inv_level_i,
  output logic      pin11_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin role select
  // The block wins while it drives; otherwise the far side's level shows.
  assign pin11_o = pin11_oe_i ? pin11_o_i : inv_level_i;
endmodule : lpmsc_panel_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the panel mode and size control block.
// Assumes a zero-wait APB slave and one pixel per clock.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lpmsc_pkg::*;
  localparam int DW = 12;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, line_end, seq_pwr, pwr_out, lpulse, ps;
  logic p11_i, p11_o, p11_oe, gp0_i, gp0_o, gp0_oe, inv_lvl, gp0_drv;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [DW-1:0] lut, pix;
  int n_errors, total_checks, cyc;
  // The bench stands in for the system on pin zero.
  assign gp0_i = gp0_oe ? gp0_o : gp0_drv;
  lpmsc_top #(.DW(DW)) DUT (.MCLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .LUT_DATA_I(lut), .LINE_END_I(line_end), .SEQ_POWER_I(seq_pwr),
    .PANEL_DATA_BUS_O(pix), .PANEL_POWER_OUT_O(pwr_out), .LINE_PULSE_O(lpulse),
    .PANEL_DATA_BIT11_PIN_I(p11_i), .PANEL_DATA_BIT11_PIN_O(p11_o),
    .PANEL_DATA_BIT11_PIN_OE_O(p11_oe), .GENERAL_PIN_ZERO_I(gp0_i), .GENERAL_PIN_ZERO_O(gp0_o),
    .GENERAL_PIN_ZERO_OE_O(gp0_oe), .POWER_SAVE_O(ps));
  lpmsc_panel_model u_panel (.pin11_o_i(p11_o), .pin11_oe_i(p11_oe), .inv_level_i(inv_lvl),
    .pin11_o(p11_i));
  // ==========================================================================
  // Shared tasks.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // Request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [17:0] ix, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [17:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ix, d, r, e);
  endtask : wr
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // ==========================================================================
  // Scenarios.
  task automatic t_regs;
    logic [17:0] ix [5] = '{LPMSC_IDX_MODE2, LPMSC_IDX_HSIZE, LPMSC_IDX_VSIZE_LO,
                            LPMSC_IDX_VSIZE_HI, LPMSC_IDX_LPSTART};
    logic [7:0] rv [5] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
    logic [7:0] wv [5] = '{8'h0f, 8'h7f, 8'hff, 8'h03, 8'h1f};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ix[i], 8'h00, r, e);
      chk("reset value", {24'h0, rv[i]}, r);
      wr(ix[i], 8'hff);
      apb(1'b0, ix[i], 8'h00, r, e);
      chk("masked readback", {24'h0, wv[i]}, r);
    end
    apb(1'b0, 18'h1ffe0, 8'h00, r, e);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, r);
    // A 640 by 480 panel: 640 / 8 - 1 stays above the floor of three.
    wr(LPMSC_IDX_HSIZE, 8'(640 / 8 - 1));
    apb(1'b0, LPMSC_IDX_HSIZE, 8'h00, r, e);
    chk("horizontal size", 32'(640 / 8 - 1), r);
    wr(LPMSC_IDX_VSIZE_LO, 8'hdf);
    wr(LPMSC_IDX_VSIZE_HI, 8'h01);
    apb(1'b0, LPMSC_IDX_VSIZE_HI, 8'h00, r, e);
    chk("vertical size high", 32'h1, r);
    apb(1'b0, LPMSC_IDX_VSIZE_LO, 8'h00, r, e);
    chk("vertical size low", 32'hdf, r);
    $display("test regs done");
  endtask : t_regs
  task automatic t_invert;
    wr(LPMSC_IDX_MODE2, 8'h03);
    // Pin four is set up to drive, so the invert role must take the driver away.
    wr(LPMSC_IDX_GPCFG, 8'h10);
    wr(LPMSC_IDX_GPCTL, 8'h10);
    lut <= 12'ha5c;
    for (int k = 0; k < 8; k++) begin
      wr(LPMSC_IDX_MODE1, {6'h0, k[2], k[1]});
      inv_lvl <= k[0];
      settle();
      chk("pixel", ((k[2] ? k[0] : k[1]) ? 12'h5a3 : 12'ha5c), pix);
      chk("bit eleven pin", {!k[2], 1'b1}, {p11_oe, p11_o});
    end
    $display("test invert done");
  endtask : t_invert
  task automatic t_power;
    wr(LPMSC_IDX_MODE1, 8'h00);
    seq_pwr <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(LPMSC_IDX_MODE2, {4'h0, k[2], 1'b0, k[1:0]});
      settle();
      chk("power save", (k[1:0] == 0), ps);
      chk("panel power", !(k[1:0] == 0 && k[2]), pwr_out);
      chk("panel data", ((k[1:0] == 0 && k[2]) ? 12'h0 : 12'ha5c), pix);
    end
    @(posedge clk);
    seq_pwr <= 1'b0;
    settle();
    chk("panel power off", 0, pwr_out);
    $display("test power done");
  endtask : t_power
  task automatic t_pin0;
    logic [31:0] r;
    logic e;
    wr(LPMSC_IDX_MODE2, 8'h03);
    wr(LPMSC_IDX_GPCFG, 8'h01);
    for (int v = 1; v >= 0; v--) begin
      wr(LPMSC_IDX_GPCTL, v[7:0]);
      settle();
      chk("pin zero drive", {1'b1, v[0]}, {gp0_oe, gp0_o});
    end
    wr(LPMSC_IDX_GPCFG, 8'h00);
    gp0_drv <= 1'b1;
    apb(1'b0, LPMSC_IDX_GPCTL, 8'h00, r, e);
    chk("pin zero status", {1'b0, 1'b1}, {gp0_oe, r[0]});
    wr(LPMSC_IDX_GPCFG, 8'h01);
    wr(LPMSC_IDX_MODE2, 8'h07);
    settle();
    chk("hardware save high", {1'b0, 1'b1}, {gp0_oe, ps});
    @(posedge clk);
    gp0_drv <= 1'b0;
    settle();
    chk("hardware save low", 0, ps);
    $display("test pin zero done");
  endtask : t_pin0
  task automatic t_line;
    int lps, n;
    wr(LPMSC_IDX_MODE2, 8'h03);
    wr(LPMSC_IDX_MODE1, 8'h80);
    for (int j = 0; j < 2; j++) begin
      lps = j ? 31 : 0;
      wr(LPMSC_IDX_LPSTART, lps[7:0]);
      @(posedge clk);
      line_end <= 1'b1;
      @(posedge clk);
      line_end <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        n++;
        #1;
      end while (lpulse !== 1'b1 && n < 400);
      chk("line pulse delay", (lps + LPMSC_LP_BIAS) * LPMSC_LP_UNIT, n);
    end
    // On a passive panel the same line end must produce no pulse at all.
    wr(LPMSC_IDX_MODE1, 8'h00);
    @(posedge clk);
    line_end <= 1'b1;
    @(posedge clk);
    line_end <= 1'b0;
    n = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (lpulse === 1'b1) n++;
    end
    chk("passive line pulse", 0, n);
    $display("test line pulse done");
  endtask : t_line
  // ==========================================================================
  // Clock, watchdog and main sequence.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Tests take about 800 cycles; the ceiling leaves ample room.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {rstn, psel, pen, pwr, line_end, seq_pwr, inv_lvl, gp0_drv} = '0;
    paddr = '0;
    pwdata = '0;
    lut = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_invert();
    t_power();
    t_pin0();
    t_line();
    tally_and_finish();
  end
endmodule : tb_top
bind lpmsc_top lpmsc_checker #(.DW(DW)) u_chk (.*);
`default_nettype wire
